// ===== ppp_pkg.sv
package ppp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  // least busy times, in microseconds
  localparam int unsigned T_WRITE_US = 3700;
  localparam int unsigned T_ERASE_US = 7500;
  localparam int unsigned BUSY_W = 20;

  // ----------------------------------------------------------------
  // strobe actions, entry pattern and commands
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [3:0] ENTRY_PAT = 4'h0;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR = 8'h11;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD = 8'h03;

  // ----------------------------------------------------------------
  // memory geometry and erased values
  // ----------------------------------------------------------------
  localparam int unsigned FLASH_AW = 12;
  localparam int unsigned PAGE_WORD_W = 5;
  localparam int unsigned EE_AW = 9;
  localparam int unsigned EE_WORD_W = 2;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned WALK_W = 13;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // fuse and lock reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam int unsigned KEEP_EE_BIT = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hv;
    logic strobe;
    logic act_hi;
    logic act_lo;
    logic bs1;
    logic bs2;
    logic latch;
    logic wr_n;
    logic oe_n;
    logic [7:0] data;
  } ppp_pins_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ERASE = 2'b01,
    OP_FLASH = 2'b10,
    OP_EE = 2'b11
  } ppp_op_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ppp_state_t;

endpackage

// ===== ppp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ===== ppp_nvm.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_nvm import ppp_pkg::*; #(
  parameter int unsigned FLASH_WORDS = 4096,
  parameter int unsigned EE_BYTES = 512,
  parameter int unsigned FPAGE_WORDS = 32,
  parameter int unsigned EPAGE_BYTES = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operation request
  input wire ppp_op_t op_i,
  input wire logic start_i,
  input wire logic [PAGE_W-1:0] page_i,
  input wire logic keep_ee_i,
  // page buffer loading
  input wire logic buf_clear_i,
  input wire logic flash_latch_i,
  input wire logic ee_latch_i,
  input wire logic [PAGE_WORD_W-1:0] word_i,
  input wire logic [15:0] wdata_i,
  // reads
  input wire logic [FLASH_AW-1:0] rd_flash_addr_i,
  input wire logic [EE_AW-1:0] rd_ee_addr_i,
  output logic [15:0] rd_flash_o,
  output logic [7:0] rd_ee_o,
  // status
  output logic walking_o,
  output logic flash_erased_o
);

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] fbuf [FPAGE_WORDS];
  logic [7:0] ebuf [EPAGE_BYTES];
  logic [WALK_W-1:0] cnt_r;
  logic [WALK_W-1:0] last;
  ppp_op_t op_r;
  logic [PAGE_W-1:0] page_r;
  logic keep_r;
  wire in_ee = cnt_r[FLASH_AW];
  wire at_end = walking_o && (cnt_r == last);

  // one word per cycle keeps a single write port on each array
  always_comb begin
    case (op_r)
      OP_ERASE: last = keep_r ? WALK_W'(FLASH_WORDS - 1)
                              : WALK_W'(FLASH_WORDS + EE_BYTES - 1);
      OP_FLASH: last = WALK_W'(FPAGE_WORDS - 1);
      OP_EE: last = WALK_W'(EPAGE_BYTES - 1);
      default: last = '0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      walking_o <= 1'b0;
      cnt_r <= '0;
      op_r <= OP_NONE;
      page_r <= '0;
      keep_r <= 1'b0;
      flash_erased_o <= 1'b0;
    end else begin
      flash_erased_o <= walking_o && op_r == OP_ERASE &&
                        cnt_r == WALK_W'(FLASH_WORDS - 1); // RULE_08
      if (start_i && !walking_o) begin
        walking_o <= 1'b1;
        cnt_r <= '0;
        op_r <= start_i ? op_i : op_r;
        page_r <= page_i;
        keep_r <= keep_ee_i; // RULE_09
      end else if (walking_o) begin
        walking_o <= !at_end;
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (walking_o) begin
      case (op_r)
        OP_ERASE: begin
          if (!in_ee) begin
            flash_mem[cnt_r[FLASH_AW-1:0]] <= ERASED_WORD; // RULE_08
          end else begin
            ee_mem[cnt_r[EE_AW-1:0]] <= ERASED_BYTE;
          end
        end
        OP_FLASH: flash_mem[{page_r, cnt_r[PAGE_WORD_W-1:0]}] <=
                    fbuf[cnt_r[PAGE_WORD_W-1:0]]; // RULE_17
        OP_EE: ee_mem[{page_r, cnt_r[EE_WORD_W-1:0]}] <=
                 ebuf[cnt_r[EE_WORD_W-1:0]]; // RULE_19
        default: ;
      endcase
    end
    rd_flash_o <= flash_mem[rd_flash_addr_i];
    rd_ee_o <= ee_mem[rd_ee_addr_i];
  end

  // buffers return to erased after each page program or a no-op
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < FPAGE_WORDS; i++) fbuf[i] <= ERASED_WORD;
      for (int i = 0; i < EPAGE_BYTES; i++) ebuf[i] <= ERASED_BYTE;
    end else if (buf_clear_i || (at_end && op_r != OP_ERASE)) begin
      for (int i = 0; i < FPAGE_WORDS; i++) fbuf[i] <= ERASED_WORD;
      for (int i = 0; i < EPAGE_BYTES; i++) ebuf[i] <= ERASED_BYTE;
    end else begin
      if (flash_latch_i) begin
        fbuf[word_i] <= wdata_i; // RULE_15
      end
      if (ee_latch_i) begin
        ebuf[word_i[EE_WORD_W-1:0]] <= wdata_i[7:0];
      end
    end
  end

endmodule
`default_nettype wire

// ===== ppp_top.sv
// Function
// RULE_01 - programmer holds entry pins 0000, reset low, supply off first
// RULE_02 - programmer keeps entry pins stable 10us after high voltage
// RULE_03 - programmer waits 300us after entry before any command
// RULE_04 - mode ends at power down or reset pin low
// RULE_05 - last command and address stay loaded across operations
// RULE_06 - programmer may skip 0xFF bytes after an erase
// RULE_07 - address high byte stays valid until reloaded
// RULE_08 - full erase clears flash, eeprom, then locks; fuses untouched
// RULE_09 - keep-eeprom fuse programmed preserves eeprom during full erase
// RULE_10 - programmer erases fully before reprogramming memory
// RULE_11 - strobe action: 10 command, 00 address, 01 data
// RULE_12 - command 1000 0000 plus write pulse runs erase, busy low
// RULE_13 - command 0001 0000 is flash page write
// RULE_14 - first byte select routes address and data bytes low/high
// RULE_15 - page latch with byte select 1 stores word into buffer
// RULE_16 - low address bits pick word, upper bits pick page
// RULE_17 - write pulse programs buffered flash page while busy
// RULE_18 - command 0000 0000 is no-op clearing internal write state
// RULE_19 - eeprom page write with command 0001 0001, select 0
// RULE_20 - flash read drives low or high byte by byte select
// RULE_21 - eeprom read drives addressed byte with select 0
// RULE_22 - fuse write by data byte; selects pick low/high/extended
// RULE_23 - ready/busy low while programming, high when ready
// RULE_24 - action 11 on strobe does nothing
// RULE_25 - second byte select picks the extended fuse byte
// RULE_26 - data bus driven only while output enable is low
// RULE_27 - data bus released while output enable is high
`timescale 1ns/1ns
`default_nettype none
module ppp_top import ppp_pkg::*; #(
  parameter int unsigned WRITE_CYC = T_WRITE_US * CLK_MHZ,
  parameter int unsigned ERASE_CYC = T_ERASE_US * CLK_MHZ
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // high voltage present on the reset pin
  input wire logic PROG_HV_I,
  // programming control pins
  input wire logic LOAD_STROBE_PIN_I,
  input wire logic ACTION_SEL_HI_I,
  input wire logic ACTION_SEL_LO_I,
  input wire logic BYTE_SEL_PRIMARY_I,
  input wire logic BYTE_SEL_SECONDARY_I,
  input wire logic PAGE_BUFFER_LATCH_I,
  input wire logic WRITE_N_I,
  input wire logic OUTPUT_EN_N_I,
  // data bus
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_N_O,
  // status
  output logic READY_BUSY_OUT_O,
  output logic PROG_MODE_O,
  output logic [7:0] FUSE_LOW_O,
  output logic [7:0] FUSE_HIGH_O,
  output logic [7:0] FUSE_EXT_O,
  output logic [7:0] LOCK_BITS_O
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic ppp_op_t cmd_to_op(input logic [7:0] cmd);
    case (cmd)
      CMD_ERASE: cmd_to_op = OP_ERASE;
      CMD_FLASH_WR: cmd_to_op = OP_FLASH; // RULE_13
      CMD_EE_WR: cmd_to_op = OP_EE;
      default: cmd_to_op = OP_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------------------------------
  ppp_pins_t pin_raw;
  ppp_pins_t pin_s;

  assign pin_raw = {PROG_HV_I, LOAD_STROBE_PIN_I, ACTION_SEL_HI_I,
                    ACTION_SEL_LO_I, BYTE_SEL_PRIMARY_I,
                    BYTE_SEL_SECONDARY_I, PAGE_BUFFER_LATCH_I,
                    WRITE_N_I, OUTPUT_EN_N_I, DATA_I};

  // data and controls share the strobe's latency, so a strobe edge
  // sees the byte that was set up before the pin edge
  ppp_sync #(
    .WIDTH($bits(ppp_pins_t))
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  logic hv_d_r;
  logic strobe_d_r;
  logic latch_d_r;
  logic wr_n_d_r;

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      hv_d_r <= 1'b0;
      strobe_d_r <= 1'b0;
      latch_d_r <= 1'b0;
      wr_n_d_r <= 1'b0;
    end else begin
      hv_d_r <= pin_s.hv;
      strobe_d_r <= pin_s.strobe;
      latch_d_r <= pin_s.latch;
      wr_n_d_r <= pin_s.wr_n;
    end
  end

  wire hv_rise = pin_s.hv && !hv_d_r;
  wire strobe_rise = pin_s.strobe && !strobe_d_r;
  wire latch_rise = pin_s.latch && !latch_d_r;
  wire wr_fall = !pin_s.wr_n && wr_n_d_r;
  wire [1:0] act = {pin_s.act_hi, pin_s.act_lo};
  wire [3:0] entry_pins = {pin_s.latch, pin_s.act_hi, pin_s.act_lo,
                           pin_s.bs1};

  // ----------------------------------------------------------------
  // programming mode
  // ----------------------------------------------------------------
  logic prog_mode_r;
  logic prog_mode_nxt;

  // the pattern is taken as the high voltage arrives; holding it a
  // while longer is the programmer's duty
  assign prog_mode_nxt = !pin_s.hv ? 1'b0 : // RULE_04
                         (hv_rise && entry_pins == ENTRY_PAT) ? 1'b1 :
                         prog_mode_r;

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      prog_mode_r <= 1'b0;
    end else begin
      prog_mode_r <= prog_mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  ppp_state_t state_r;
  ppp_state_t state_nxt;
  logic [BUSY_W-1:0] busy_cnt_r;
  logic [BUSY_W-1:0] busy_cnt_nxt;
  logic walking;
  logic flash_erased;

  // strobes and pulses are ignored while busy or outside the mode
  wire take = prog_mode_r && state_r == ST_IDLE;

  // ----------------------------------------------------------------
  // command, address and data loading
  // ----------------------------------------------------------------
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] addr_hi_r;
  logic [7:0] addr_hi_nxt;
  logic [7:0] addr_lo_r;
  logic [7:0] addr_lo_nxt;
  logic [7:0] data_hi_r;
  logic [7:0] data_hi_nxt;
  logic [7:0] data_lo_r;
  logic [7:0] data_lo_nxt;

  wire cmd_load = take && strobe_rise && act == ACT_CMD; // RULE_11
  wire addr_load = take && strobe_rise && act == ACT_ADDR;
  wire data_load = take && strobe_rise && act == ACT_DATA;
  // an idle action code falls through every load above  RULE_24

  // within the mode, values persist until the next load of the same kind  RULE_05
  assign cmd_nxt = !prog_mode_r ? CMD_NOP :
                   cmd_load ? pin_s.data : cmd_r;
  assign addr_hi_nxt = !prog_mode_r ? 8'h00 :
                       (addr_load && pin_s.bs1) ? pin_s.data : // RULE_07
                       addr_hi_r;
  assign addr_lo_nxt = !prog_mode_r ? 8'h00 :
                       (addr_load && !pin_s.bs1) ? pin_s.data : // RULE_14
                       addr_lo_r;
  assign data_hi_nxt = (data_load && pin_s.bs1) ? pin_s.data : // RULE_14
                       data_hi_r;
  assign data_lo_nxt = (data_load && !pin_s.bs1) ? pin_s.data :
                       data_lo_r;

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      cmd_r <= CMD_NOP;
      addr_hi_r <= 8'h00;
      addr_lo_r <= 8'h00;
      data_hi_r <= ERASED_BYTE;
      data_lo_r <= ERASED_BYTE;
    end else begin
      cmd_r <= cmd_nxt;
      addr_hi_r <= addr_hi_nxt;
      addr_lo_r <= addr_lo_nxt;
      data_hi_r <= data_hi_nxt;
      data_lo_r <= data_lo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // page buffer and operation requests
  // ----------------------------------------------------------------
  wire [15:0] full_addr = {addr_hi_r, addr_lo_r};
  wire ppp_op_t op_sel = cmd_to_op(cmd_r);
  wire [PAGE_W-1:0] page_sel = (op_sel == OP_EE) ?
       full_addr[EE_AW-1:EE_WORD_W] :
       full_addr[FLASH_AW-1:PAGE_WORD_W]; // RULE_16
  wire flash_latch = take && latch_rise && pin_s.bs1 &&
                     cmd_r == CMD_FLASH_WR; // RULE_15
  wire ee_latch = take && latch_rise && cmd_r == CMD_EE_WR;
  wire buf_clear = cmd_load && pin_s.data == CMD_NOP; // RULE_18
  wire wr_go = take && wr_fall;
  wire nvm_go = wr_go && (op_sel == OP_ERASE || // RULE_12
                op_sel == OP_FLASH || // RULE_17
                (op_sel == OP_EE && !pin_s.bs1)); // RULE_19
  wire fuse_go = wr_go && cmd_r == CMD_FUSE_WR;
  wire lock_go = wr_go && cmd_r == CMD_LOCK_WR;
  wire busy_go = nvm_go || fuse_go || lock_go;

  // ----------------------------------------------------------------
  // fuses and lock bits
  // ----------------------------------------------------------------
  logic [7:0] fuse_lo_r;
  logic [7:0] fuse_hi_r;
  logic [7:0] fuse_ext_r;
  logic [7:0] lock_r;

  wire fuse_lo_sel = !pin_s.bs1 && !pin_s.bs2; // RULE_22
  wire fuse_hi_sel = pin_s.bs1 && !pin_s.bs2; // RULE_22
  wire fuse_ext_sel = !pin_s.bs1 && pin_s.bs2; // RULE_25
  // a programmed bit reads 0, so the erase guard is the inverted bit
  wire keep_ee = !fuse_hi_r[KEEP_EE_BIT]; // RULE_09

  // erase never touches the fuses; locks reopen only once the whole
  // flash has been walked
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      fuse_lo_r <= FUSE_LO_RST;
      fuse_hi_r <= FUSE_HI_RST;
      fuse_ext_r <= FUSE_EXT_RST;
      lock_r <= LOCK_RST;
    end else begin
      if (fuse_go && fuse_lo_sel) begin
        fuse_lo_r <= data_lo_r; // RULE_22
      end
      if (fuse_go && fuse_hi_sel) begin
        fuse_hi_r <= data_lo_r;
      end
      if (fuse_go && fuse_ext_sel) begin
        fuse_ext_r <= data_lo_r; // RULE_25
      end
      if (flash_erased) begin
        lock_r <= LOCK_RST; // RULE_08
      end else if (lock_go) begin
        lock_r <= lock_r & data_lo_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // busy sequencing
  // ----------------------------------------------------------------
  wire busy_done = busy_cnt_r == '0 && !walking;

  always_comb begin
    state_nxt = state_r;
    busy_cnt_nxt = busy_cnt_r;
    if (busy_cnt_r != '0) begin
      busy_cnt_nxt = busy_cnt_r - 1'b1;
    end
    case (state_r)
      ST_OFF: begin
        if (prog_mode_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (busy_go) begin
          state_nxt = ST_BUSY; // RULE_23
          busy_cnt_nxt = (op_sel == OP_ERASE) ?
                         BUSY_W'(ERASE_CYC - 1) :
                         BUSY_W'(WRITE_CYC - 1);
        end
      end
      ST_BUSY: begin
        if (busy_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!prog_mode_r) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= ST_OFF;
      busy_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  logic [15:0] rd_flash;
  logic [7:0] rd_ee;

  ppp_nvm u_nvm (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .op_i(op_sel),
    .start_i(nvm_go),
    .page_i(page_sel),
    .keep_ee_i(keep_ee),
    .buf_clear_i(buf_clear),
    .flash_latch_i(flash_latch),
    .ee_latch_i(ee_latch),
    .word_i(addr_lo_r[PAGE_WORD_W-1:0]),
    .wdata_i({data_hi_r, data_lo_r}),
    .rd_flash_addr_i(full_addr[FLASH_AW-1:0]),
    .rd_ee_addr_i(full_addr[EE_AW-1:0]),
    .rd_flash_o(rd_flash),
    .rd_ee_o(rd_ee),
    .walking_o(walking),
    .flash_erased_o(flash_erased)
  );

  // ----------------------------------------------------------------
  // read data and bus drive
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (cmd_r)
      CMD_FLASH_RD: rd_byte = pin_s.bs1 ? rd_flash[15:8] : // RULE_20
                              rd_flash[7:0];
      CMD_EE_RD: rd_byte = pin_s.bs1 ? ERASED_BYTE : rd_ee; // RULE_21
      default: rd_byte = ERASED_BYTE;
    endcase
  end

  wire drive = prog_mode_r && !pin_s.oe_n; // RULE_26

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      DATA_O <= 8'h00;
      DATA_OE_N_O <= 1'b1;
      READY_BUSY_OUT_O <= 1'b1;
      PROG_MODE_O <= 1'b0;
      FUSE_LOW_O <= FUSE_LO_RST;
      FUSE_HIGH_O <= FUSE_HI_RST;
      FUSE_EXT_O <= FUSE_EXT_RST;
      LOCK_BITS_O <= LOCK_RST;
    end else begin
      DATA_O <= drive ? rd_byte : 8'h00;
      DATA_OE_N_O <= !drive; // RULE_27
      READY_BUSY_OUT_O <= state_nxt != ST_BUSY; // RULE_23
      PROG_MODE_O <= prog_mode_r;
      FUSE_LOW_O <= fuse_lo_r;
      FUSE_HIGH_O <= fuse_hi_r;
      FUSE_EXT_O <= fuse_ext_r;
      LOCK_BITS_O <= lock_r;
    end
  end

endmodule
`default_nettype wire

// ===== ppp_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_properties import ppp_pkg::*; #(
  parameter int unsigned WRITE_CYC = 200,
  parameter int unsigned ERASE_CYC = 6000
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // watched pins
  input wire logic PROG_HV_I,
  input wire logic OUTPUT_EN_N_I,
  input wire logic [7:0] DATA_O,
  input wire logic DATA_OE_N_O,
  input wire logic READY_BUSY_OUT_O,
  input wire logic PROG_MODE_O,
  input wire logic [7:0] FUSE_LOW_O,
  input wire logic [7:0] FUSE_HIGH_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  // saturates so a stuck busy still trips the upper bound
  logic [BUSY_W-1:0] busy_cnt_r;
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) busy_cnt_r <= '0;
    else if (READY_BUSY_OUT_O) busy_cnt_r <= '0;
    else if (!(&busy_cnt_r)) busy_cnt_r <= busy_cnt_r + 1'b1;
  end
  a_bus_release: assert property (OUTPUT_EN_N_I[*5] |-> DATA_OE_N_O)
    else $error("data bus driven with output enable high");
  a_drive_cause: assert property ($fell(DATA_OE_N_O) |->
    !$past(OUTPUT_EN_N_I, 2) && PROG_MODE_O)
    else $error("data bus driven without output enable");
  a_idle_zero: assert property (DATA_OE_N_O |-> DATA_O == 8'h00)
    else $error("data out not zero while released");
  a_busy_mode: assert property (!READY_BUSY_OUT_O |-> PROG_MODE_O)
    else $error("busy outside programming mode");
  a_mode_exit: assert property (!PROG_HV_I [*6] |-> !PROG_MODE_O)
    else $error("mode kept without high voltage");
  a_fuse_hold: assert property (!PROG_MODE_O |=>
    $stable(FUSE_LOW_O) && $stable(FUSE_HIGH_O))
    else $error("fuse changed outside programming mode");
  a_busy_min: assert property ($rose(READY_BUSY_OUT_O) &&
    PROG_MODE_O |-> busy_cnt_r >= WRITE_CYC - 1)
    else $error("busy span too short");
  a_busy_max: assert property (!READY_BUSY_OUT_O |->
    busy_cnt_r < ERASE_CYC + 4700)
    else $error("busy span too long");
  cover property ($fell(READY_BUSY_OUT_O));
  cover property ($fell(DATA_OE_N_O));
  cover property ($rose(PROG_MODE_O));
endmodule
bind ppp_top ppp_properties #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC))
  u_props (.*);
`default_nettype wire

// ===== ppp_prog.sv
`timescale 1ns/1ns
`default_nettype none
module ppp_prog import ppp_pkg::*; (
  // clock and device answer
  input wire logic clk_i,
  input wire logic rdy_i,
  input wire logic [7:0] dout_i,
  input wire logic doe_n_i,
  // pins and resolved data bus
  output ppp_pins_t pins_o,
  output logic [7:0] bus_o
);
  localparam int unsigned ENTRY_WAIT = 300 * CLK_MHZ;
  // a released bus shows the inverse, not a stale copy
  assign bus_o = !doe_n_i ? dout_i : pins_o.oe_n ? pins_o.data : ~pins_o.data;
  initial pins_o = '{wr_n: 1'b1, oe_n: 1'b1, default: 1'b0};
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic enter;
    tick(4);
    pins_o.hv = 1'b1;
    tick(ENTRY_WAIT);
  endtask
  task automatic leave;
    pins_o.hv = 1'b0;
    tick(8);
  endtask
  // one 96 ns strobe period per load
  task automatic ld(input logic [1:0] act, logic bs1, logic [7:0] d);
    {pins_o.act_hi, pins_o.act_lo} = act;
    pins_o.bs1 = bs1;
    pins_o.data = d;
    tick(4);
    pins_o.strobe = 1'b1;
    tick(4);
    pins_o.strobe = 1'b0;
    tick(4);
  endtask
  task automatic latch(input logic bs1);
    pins_o.bs1 = bs1;
    tick(4);
    pins_o.latch = 1'b1;
    tick(4);
    pins_o.latch = 1'b0;
    tick(4);
  endtask
  task automatic wr(input logic bs1, input logic bs2, output logic seen);
    pins_o.bs1 = bs1;
    pins_o.bs2 = bs2;
    tick(4);
    pins_o.wr_n = 1'b0;
    tick(4);
    pins_o.wr_n = 1'b1;
    seen = (rdy_i === 1'b0);
    for (int i = 0; i < 20000 && rdy_i !== 1'b1; i++) tick(1);
    pins_o.bs1 = 1'b0;
    pins_o.bs2 = 1'b0;
  endtask
  task automatic rd(output logic [15:0] v);
    pins_o.bs1 = 1'b0;
    pins_o.oe_n = 1'b0;
    tick(6);
    v[7:0] = bus_o;
    pins_o.bs1 = 1'b1;
    tick(6);
    v[15:8] = bus_o;
    pins_o.oe_n = 1'b1;
    pins_o.bs1 = 1'b0;
    tick(6);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench import ppp_pkg::*;;
  logic clk;
  logic rst;
  logic [7:0] dout;
  logic doe_n;
  logic rdy;
  logic mode;
  logic [7:0] f_lo, f_hi, f_ext, lock;
  logic [7:0] bus;
  ppp_pins_t pins;
  int bad_count, samples_checked, seed;
  logic seen;
  ppp_prog u_prog (.clk_i(clk), .rdy_i(rdy), .dout_i(dout), .doe_n_i(doe_n),
    .pins_o(pins), .bus_o(bus));
  ppp_top #(.WRITE_CYC(200), .ERASE_CYC(6000)) DUT (
    .CLK_SYS_I(clk), .RESET_I(rst), .PROG_HV_I(pins.hv),
    .LOAD_STROBE_PIN_I(pins.strobe), .ACTION_SEL_HI_I(pins.act_hi),
    .ACTION_SEL_LO_I(pins.act_lo), .BYTE_SEL_PRIMARY_I(pins.bs1),
    .BYTE_SEL_SECONDARY_I(pins.bs2), .PAGE_BUFFER_LATCH_I(pins.latch),
    .WRITE_N_I(pins.wr_n), .OUTPUT_EN_N_I(pins.oe_n), .DATA_I(bus),
    .DATA_O(dout), .DATA_OE_N_O(doe_n), .READY_BUSY_OUT_O(rdy),
    .PROG_MODE_O(mode), .FUSE_LOW_O(f_lo), .FUSE_HIGH_O(f_hi),
    .FUSE_EXT_O(f_ext), .LOCK_BITS_O(lock));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] f_addr(input logic [6:0] pg, logic [4:0] w);
    return {4'h0, pg, w};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_at(logic [7:0] c, logic [15:0] a, output logic [15:0] v);
    u_prog.ld(ACT_CMD, 1'b0, c);
    u_prog.ld(ACT_ADDR, 1'b1, a[15:8]);
    u_prog.ld(ACT_ADDR, 1'b0, a[7:0]);
    u_prog.ld(ACT_IDLE, 1'b0, ~a[7:0]);
    u_prog.rd(v);
  endtask
  task automatic erase;
    u_prog.ld(ACT_CMD, 1'b0, CMD_ERASE);
    u_prog.wr(1'b0, 1'b0, seen);
    chk({seen, rdy}, 2'b11);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #700000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    logic [15:0] mem [4];
    logic [4:0] wd [4];
    logic [7:0] fz [4];
    logic [15:0] a;
    logic [15:0] v;
    logic [15:0] ea;
    logic [7:0] ee_v;
    logic [6:0] pg;
    seed = 60850;
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    chk({f_lo, f_hi, f_ext, lock},
        {FUSE_LO_RST, FUSE_HI_RST, FUSE_EXT_RST, LOCK_RST});
    u_prog.enter();
    chk(mode, 1'b1);
    erase();
    pg = 7'($random(seed));
    wd = '{5'h00, 5'h01, 5'h1E, 5'h1F};
    u_prog.ld(ACT_CMD, 1'b0, CMD_FLASH_WR);
    foreach (wd[i]) begin
      a = f_addr(pg, wd[i]);
      mem[i] = 16'($random(seed));
      u_prog.ld(ACT_ADDR, 1'b0, a[7:0]);
      u_prog.ld(ACT_DATA, 1'b0, mem[i][7:0]);
      u_prog.ld(ACT_DATA, 1'b1, mem[i][15:8]);
      u_prog.latch(1'b1);
    end
    u_prog.ld(ACT_ADDR, 1'b1, a[15:8]);
    u_prog.wr(1'b0, 1'b0, seen);
    chk({seen, rdy}, 2'b11);
    u_prog.ld(ACT_CMD, 1'b0, CMD_NOP);
    rd_at(CMD_FLASH_RD, f_addr(pg, wd[0]), v);
    chk(v, mem[0]);
    for (int i = 1; i < 5; i++) begin
      a = f_addr(pg, i < 4 ? wd[i] : 5'h02);
      u_prog.ld(ACT_ADDR, 1'b0, a[7:0]);
      u_prog.rd(v);
      chk(v, i < 4 ? mem[i] : ERASED_WORD);
    end
    ea = 16'($random(seed)) & 16'h01FF;
    ee_v = 8'($random(seed));
    u_prog.ld(ACT_CMD, 1'b0, CMD_EE_WR);
    u_prog.ld(ACT_ADDR, 1'b1, ea[15:8]);
    u_prog.ld(ACT_ADDR, 1'b0, ea[7:0]);
    u_prog.ld(ACT_DATA, 1'b0, ee_v);
    u_prog.latch(1'b0);
    u_prog.wr(1'b0, 1'b0, seen);
    chk({seen, rdy}, 2'b11);
    rd_at(CMD_EE_RD, ea, v);
    chk(v, {ERASED_BYTE, ee_v});
    u_prog.ld(ACT_CMD, 1'b0, CMD_FUSE_WR);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) u_prog.ld(ACT_CMD, 1'b0, CMD_LOCK_WR);
      fz[i] = 8'($random(seed));
      if (i == 0) fz[i][KEEP_EE_BIT] = 1'b0;
      u_prog.ld(ACT_DATA, 1'b0, fz[i]);
      u_prog.wr(i == 0, i == 1, seen);
      chk({seen, rdy}, 2'b11);
    end
    chk({f_hi, f_ext, f_lo, lock}, {fz[0], fz[1], fz[2], fz[3]});
    erase();
    chk({f_hi, f_ext, f_lo, lock}, {fz[0], fz[1], fz[2], LOCK_RST});
    rd_at(CMD_EE_RD, ea, v);
    chk(v[7:0], ee_v);
    rd_at(CMD_FLASH_RD, f_addr(pg, wd[3]), v);
    chk(v, ERASED_WORD);
    chk(doe_n, 1'b1);
    u_prog.leave();
    chk(mode, 1'b0);
    u_prog.ld(ACT_CMD, 1'b0, CMD_ERASE);
    u_prog.wr(1'b0, 1'b0, seen);
    chk({seen, rdy}, 2'b01);
    report_and_stop;
  end
endmodule
`default_nettype wire
